/* File: logic/tcp_cfg.svh */
// Purpose: Constants for the timer compare and periodic interrupt block
// Assumes: APB byte addresses, one register per aligned 32-bit word
// Notes: Offsets are local choices; field positions follow the flag layout
`ifndef TCP_CFG_SVH
`define TCP_CFG_SVH
// =====================================================================
// Register offsets
`define TCP_OFF_COUNT_HI 12'h000
`define TCP_OFF_COUNT_LO 12'h004
`define TCP_OFF_PIN_CTRL 12'h008
`define TCP_OFF_CC_MASK 12'h00c
`define TCP_OFF_CC_FLAGS 12'h010
`define TCP_OFF_MISC_MASK 12'h014
`define TCP_OFF_MISC_FLAGS 12'h018
`define TCP_OFF_ACC_CTRL 12'h01c
`define TCP_OFF_COMPARE_BASE 12'h020
// =====================================================================
// Field positions
`define TCP_BIT_WRAP 7
`define TCP_BIT_PERIODIC 6
`define TCP_BIT_CH4_SEL 2
`define TCP_BIT_CH4 3
`define TCP_MISC_MASK_RW 8'hf3
`define TCP_MISC_FLAG_MASK 8'hc0
`define TCP_ACC_CTRL_RW 8'hff
// =====================================================================
// Reset values and timing
`define TCP_COMPARE_RESET 16'hffff
`define TCP_PRESCALE_WINDOW_CYCLES 7'd64
`define TCP_PERIODIC_BASE_LOG2 13
`endif

/* File: logic/tcp_pkg.sv */
// Purpose: Types for the timer compare and periodic interrupt block
// Assumes: Constants live in tcp_cfg.svh
// Notes: Pin action encoding of the two-bit mode/level field
package tcp_pkg;
  // =====================================================================
  // Pin action per compare channel
  typedef enum logic [1:0] {
    TCP_ACT_OFF = 2'h0,
    TCP_ACT_TOGGLE = 2'h1,
    TCP_ACT_LOW = 2'h2,
    TCP_ACT_HIGH = 2'h3
  } tcp_action_e;
endpackage

/* File: logic/tcp_timer.sv */
// Purpose: Free-running timer, compare pins, flags and periodic interrupt
// Assumes: Single pclk domain, APB slave, zero wait states
// Notes: Capture edges arrive as one-cycle pulses from outside
// How it works
// - High-byte read latches low byte coherently
// - Count register ignores writes
// - Mode/level field picks pin action
// - Channel five acts only when select clear
// - Compare flag and enable raise interrupt
// - Capture flag and enable raise interrupt
// - Shared enable follows channel-four select
// - Mask bit gates same-position flag
// - Write one clears flag, zero keeps
// - Counter match sets compare flag
// - Capture edge sets capture flag
// - Shared flag source follows select
// - Wrap to zero sets wrap flag
// - Wrap enable gates wrap interrupt
// - Prescale select writable once, first 64 cycles
// - Prescale codes divide by 1, 4, 8, 16
// - Periodic base 2^13 times rate factor
// - Periodic divider ignores timer prescaler
// - Period runs from previous timeout
// - Timeout sets flag; enable raises interrupt
// - First flag after one full period
// - Bit six write clears periodic flag
// - Select one means capture, zero compare
`include "tcp_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module tcp_timer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] capture_edge,
  output logic [5:2] compare_pin,
  output logic [5:2] compare_pin_en,
  output logic irq
);
  // =====================================================================
  // Bus decode
  // Zero wait states keep the master model simple
  wire wr_en = psel & penable & pwrite;
  wire rd_en = psel & penable & ~pwrite;
  wire [11:0] cmp_off = paddr - `TCP_OFF_COMPARE_BASE;
  wire cmp_hit = (paddr >= `TCP_OFF_COMPARE_BASE) && (cmp_off[11:2] < 10'd5) && (cmp_off[1:0] == 2'h0);
  wire [2:0] cmp_idx = cmp_off[4:2];
  wire known = cmp_hit || (paddr[1:0] == 2'h0 && paddr < `TCP_OFF_COMPARE_BASE);
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~known;

  // =====================================================================
  // Registers
  logic [15:0] count; // Free-running count
  logic [7:0] lo_latch; // Low byte held after a high read
  logic [7:0] pin_ctrl; // Mode/level pairs, channel 2 at top
  logic [7:0] cc_mask; // Compare/capture enables
  logic [7:0] cc_flags; // Compare/capture flags
  logic [7:0] misc_mask; // Wrap, periodic enables, prescale
  logic [7:0] misc_flags; // Wrap and periodic flags
  logic [7:0] acc_ctrl; // Channel-four select and periodic rate
  logic [15:0] compare [5]; // Compare values, channels 1..5
  logic [6:0] boot_cnt; // Cycles since reset, saturating
  logic prescale_done; // Prescale written once
  logic [3:0] pre_cnt; // Timer prescaler
  logic [15:0] rti_cnt; // Periodic divider
  logic [5:2] pin_q; // Compare pin levels

  wire ch4_capture = acc_ctrl[`TCP_BIT_CH4_SEL];
  wire [1:0] prescale = misc_mask[1:0];
  wire [1:0] rate = acc_ctrl[1:0];

  // Divider terminal value per prescale code
  function automatic logic [3:0] pre_max(input logic [1:0] code);
    unique case (code)
      2'h0: pre_max = 4'd0;
      2'h1: pre_max = 4'd3;
      2'h2: pre_max = 4'd7;
      2'h3: pre_max = 4'd15;
    endcase
  endfunction

  // =====================================================================
  // Counter tick and match detection
  wire tick = (pre_cnt >= pre_max(prescale));
  wire wrap = tick && (count == 16'hffff);
  logic [4:0] match; // Channels 1..5 compare equal this tick
  always_comb
  begin
    for (int i = 0; i < 5; i++)
    begin
      match[i] = tick && (count + 16'h0001 == compare[i]);
    end
  end

  // Periodic timeout: base 2^13 scaled by rate
  // period 2^(13+rate)
  wire [15:0] rti_max = 16'((32'd1 << (`TCP_PERIODIC_BASE_LOG2 + 32'(rate))) - 32'd1);
  wire rti_timeout = (rti_cnt >= rti_max);

  // =====================================================================
  // Flag set terms; set wins over a same-cycle clear
  wire ch4_event = ch4_capture ? capture_edge[3] : match[4];
  wire [7:0] cc_set = {match[0], match[1], match[2], match[3], ch4_event, capture_edge[0], capture_edge[1],
    capture_edge[2]};
  wire [7:0] misc_set = {wrap, rti_timeout, 6'h00};
  wire cc_wr = wr_en && paddr == `TCP_OFF_CC_FLAGS;
  wire misc_wr = wr_en && paddr == `TCP_OFF_MISC_FLAGS;
  wire [7:0] next_cc_flags = (cc_flags & ~(cc_wr ? pwdata[7:0] : 8'h00)) | cc_set;
  wire [7:0] next_misc_flags = ((misc_flags & ~(misc_wr ? pwdata[7:0] : 8'h00)) | misc_set) & `TCP_MISC_FLAG_MASK;

  // Flag registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cc_flags <= 8'h00;
      misc_flags <= 8'h00;
    end
    else
    begin
      cc_flags <= next_cc_flags;
      misc_flags <= next_misc_flags;
    end
  end

  // =====================================================================
  // Counter and prescaler; bus writes to the count are dropped
  // no write path to count
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pre_cnt <= 4'd0;
      count <= 16'h0000;
    end
    else
    begin
      pre_cnt <= tick ? 4'd0 : pre_cnt + 4'd1;
      count <= tick ? count + 16'h0001 : count;
    end
  end

  // Periodic divider runs free; flag clears never restart it
  // restart only on timeout
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rti_cnt <= 16'h0000;
    else
      rti_cnt <= rti_timeout ? 16'h0000 : rti_cnt + 16'h0001;
  end

  // High-byte read snapshots the low byte for the next read
  // coherent two-byte read
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      lo_latch <= 8'h00;
    else if (rd_en && paddr == `TCP_OFF_COUNT_HI)
      lo_latch <= count[7:0];
  end

  // =====================================================================
  // Control registers
  // one write inside the window
  wire pre_open = !prescale_done && boot_cnt < `TCP_PRESCALE_WINDOW_CYCLES;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_ctrl <= 8'h00;
      cc_mask <= 8'h00;
      misc_mask <= 8'h00;
      acc_ctrl <= 8'h00;
      boot_cnt <= 7'd0;
      prescale_done <= 1'b0;
      for (int i = 0; i < 5; i++)
        compare[i] <= `TCP_COMPARE_RESET;
    end
    else
    begin
      if (boot_cnt < `TCP_PRESCALE_WINDOW_CYCLES)
        boot_cnt <= boot_cnt + 7'd1;
      if (wr_en && paddr == `TCP_OFF_PIN_CTRL)
        pin_ctrl <= pwdata[7:0];
      if (wr_en && paddr == `TCP_OFF_CC_MASK)
        cc_mask <= pwdata[7:0];
      if (wr_en && paddr == `TCP_OFF_ACC_CTRL)
        acc_ctrl <= pwdata[7:0] & `TCP_ACC_CTRL_RW;
      if (wr_en && paddr == `TCP_OFF_MISC_MASK)
      begin
        misc_mask[7:2] <= pwdata[7:2] & 6'h3c;
        if (pre_open)
        begin
          misc_mask[1:0] <= pwdata[1:0];
          prescale_done <= 1'b1;
        end
      end
      if (wr_en && cmp_hit)
        compare[cmp_idx] <= pwdata[15:0];
    end
  end

  // =====================================================================
  // Compare pin actions, channels 2..5
  logic [5:2] next_pin;
  always_comb
  begin
    next_pin = pin_q;
    for (int c = 2; c <= 5; c++)
    begin
      // select one makes channel four a capture
      if (match[c-1] && !(c == 5 && ch4_capture))
      begin
        unique case (tcp_pkg::tcp_action_e'(pin_ctrl[11-2*c -: 2]))
          tcp_pkg::TCP_ACT_OFF: next_pin[c] = pin_q[c];
          tcp_pkg::TCP_ACT_TOGGLE: next_pin[c] = ~pin_q[c];
          tcp_pkg::TCP_ACT_LOW: next_pin[c] = 1'b0;
          tcp_pkg::TCP_ACT_HIGH: next_pin[c] = 1'b1;
        endcase
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pin_q <= 4'h0;
    else
      pin_q <= next_pin;
  end
  assign compare_pin = pin_q;
  always_comb
  begin
    for (int c = 2; c <= 5; c++)
      compare_pin_en[c] = (pin_ctrl[11-2*c -: 2] != 2'h0) && !(c == 5 && ch4_capture);
  end

  // =====================================================================
  // Interrupt request
  // mask gates flags bitwise
  assign irq = |(cc_flags & cc_mask) | |(misc_flags & misc_mask & `TCP_MISC_FLAG_MASK);

  // =====================================================================
  // Read data, decoded combinationally from the address
  logic [7:0] rd_byte;
  always_comb
  begin
    rd_byte = 8'h00;
    unique case (paddr)
      `TCP_OFF_COUNT_HI: rd_byte = count[15:8];
      `TCP_OFF_COUNT_LO: rd_byte = lo_latch;
      `TCP_OFF_PIN_CTRL: rd_byte = pin_ctrl;
      `TCP_OFF_CC_MASK: rd_byte = cc_mask;
      `TCP_OFF_CC_FLAGS: rd_byte = cc_flags;
      `TCP_OFF_MISC_MASK: rd_byte = misc_mask;
      `TCP_OFF_MISC_FLAGS: rd_byte = misc_flags;
      `TCP_OFF_ACC_CTRL: rd_byte = acc_ctrl;
      default: rd_byte = 8'h00;
    endcase
  end
  // Combinational read path: prdata valid during the access phase
  assign prdata = cmp_hit ? {16'h0000, compare[cmp_idx]} : {24'h000000, rd_byte};

  // =====================================================================
  // Checks
  a_wrap_sets_flag: assert property (@(posedge pclk) disable iff (!presetn) wrap |=> misc_flags[`TCP_BIT_WRAP])
    else $error("wrap did not set flag");
  a_rti_period: assert property (@(posedge pclk) disable iff (!presetn)
    rti_timeout && rate == 2'h0 && $stable(rate) |=> !rti_timeout [*8])
    else $error("periodic timeout too soon");
  a_flag_set_wins: assert property (@(posedge pclk) disable iff (!presetn) cc_set[7] |=> cc_flags[7])
    else $error("set lost to clear");
  a_irq_gating: assert property (@(posedge pclk) disable iff (!presetn)
    (cc_flags & cc_mask) != 8'h00 |-> irq)
    else $error("masked flag not raising irq");
  a_prescale_lock: assert property (@(posedge pclk) disable iff (!presetn)
    prescale_done |=> $stable(prescale))
    else $error("prescale changed after lock");
  a_count_ro: assert property (@(posedge pclk) disable iff (!presetn)
    !tick |=> $stable(count))
    else $error("count moved without tick");
  a_pin_high: assert property (@(posedge pclk) disable iff (!presetn)
    match[1] && pin_ctrl[7:6] == 2'h3 |=> compare_pin[2])
    else $error("pin not driven high");
  a_ch5_gated: assert property (@(posedge pclk) disable iff (!presetn)
    ch4_capture && $past(ch4_capture) |-> $stable(compare_pin[5]))
    else $error("channel five acted under capture");
  a_rti_clear: assert property (@(posedge pclk) disable iff (!presetn)
    misc_wr && pwdata[6] && !rti_timeout |=> !misc_flags[6])
    else $error("periodic flag not cleared");
endmodule
`default_nettype wire

/* File: tb/test_timer_compare_and_periodic_irq.sv */
// Purpose: Self-checking bench for the timer compare and periodic interrupt block
// Assumes: Zero-wait APB slave; periodic base period of 8192 pclk cycles
// Notes: Reads and output looks are noted in a queue and judged by a monitor
`include "tcp_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module test_timer_compare_and_periodic_irq;
  // Note: kind 0 read, 1 pin outputs, 2 irq; bit 32 is pslverr
  typedef struct {logic [1:0] k; logic [32:0] e; logic [32:0] c; string n;} tcp_note_s;
  // =====================================================================
  // Signals
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, irq;
  logic [3:0] capture_edge = 4'h0;
  logic [5:2] compare_pin, compare_pin_en;
  // Strobe asking the monitor to judge a non-bus output
  logic look = 1'b0;
  tcp_note_s q[$];
  int n_mismatch = 0;
  int checked = 0;
  int cyc = 0;
  int t0 = 0; // Cycle count at the latest reset release
  integer seed = 26266;
  logic [31:0] r;
  logic [32:0] seen;
  // Clock at 50 MHz
  always #10 pclk = ~pclk;
  tcp_timer dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .capture_edge(capture_edge), .compare_pin(compare_pin), .compare_pin_en(compare_pin_en), .irq(irq));
  // =====================================================================
  // Verdict and hang guard
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Cycle count while out of reset; ceiling well above the ~83k cycle plan
  always @(posedge pclk)
  begin
    if (presetn)
      cyc <= cyc + 1;
    if (cyc == 90000)
    begin
      n_mismatch = n_mismatch + 1;
      close_out();
    end
  end
  // =====================================================================
  // Monitor: oldest note judged at each read access or look strobe
  always @(posedge pclk)
  begin
    if ((psel && penable && pready && !pwrite) || look)
    begin
      seen = look ? (q[0].k == 2'h1 ? {25'h0, compare_pin_en, compare_pin} : {32'h0, irq}) : {pslverr, prdata};
      checked = checked + 1;
      if ((seen & q[0].c) !== (q[0].e & q[0].c))
      begin
        n_mismatch = n_mismatch + 1;
        $display("wrong value %s expected %h seen %h", q[0].n, q[0].e & q[0].c, seen & q[0].c);
      end
      void'(q.pop_front());
    end
  end
  // =====================================================================
  // Drivers
  task automatic note(input logic [1:0] k, input logic [32:0] e, input logic [32:0] c, input string n);
    q.push_back('{k, e, c, n});
  endtask
  // One APB transfer; holds the request until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] c, input string n);
    note(2'h0, {1'b0, e}, {1'b1, c}, n);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic peek(input logic [1:0] k, input logic [32:0] e, input logic [32:0] c, input string n);
    note(k, e, c, n);
    @(posedge pclk);
    look <= 1'b1;
    @(posedge pclk);
    look <= 1'b0;
  endtask
  task automatic pulse(input logic [3:0] v);
    @(posedge pclk);
    capture_edge <= v;
    @(posedge pclk);
    capture_edge <= 4'h0;
  endtask
  task automatic wait_to(input int n);
    while (cyc < n)
      @(posedge pclk);
  endtask
  task automatic done(input string n);
    $display("test %s finished", n);
  endtask
  // =====================================================================
  // Main sequence
  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    // Prescale /4 first so the match times below are known
    apb(1'b1, `TCP_OFF_MISC_MASK, 32'h1);
    apb(1'b1, `TCP_OFF_MISC_MASK, 32'h2);
    rd(`TCP_OFF_MISC_MASK, 32'h1, 32'hff, "prescale select");
    rd(`TCP_OFF_COUNT_LO, 32'h0, 32'hff, "latched low byte");
    for (int i = 0; i < 5; i++)
      apb(1'b1, `TCP_OFF_COMPARE_BASE + 12'(4 * i), (i == 0) ? 32'h80 : 32'ha0);
    apb(1'b1, `TCP_OFF_PIN_CTRL, 32'he7);
    apb(1'b1, `TCP_OFF_ACC_CTRL, 32'h0);
    apb(1'b1, `TCP_OFF_CC_MASK, 32'h0);
    peek(2'h1, 33'hf0, 33'hff, "pins before match");
    done("setup");
    // Channel one meets 0x80 near cycle 506 at /4
    wait_to(470);
    rd(`TCP_OFF_CC_FLAGS, 32'h0, 32'h80, "flag before match");
    wait_to(560);
    rd(`TCP_OFF_CC_FLAGS, 32'h80, 32'h80, "flag after match");
    wait_to(700);
    peek(2'h1, 33'hfd, 33'hff, "pins after match");
    rd(`TCP_OFF_CC_FLAGS, 32'hf8, 32'hff, "match flags");
    r = $random(seed) & 32'hff;
    apb(1'b1, `TCP_OFF_CC_FLAGS, r);
    rd(`TCP_OFF_CC_FLAGS, 32'hf8 & ~r, 32'hff, "random clear");
    apb(1'b1, `TCP_OFF_CC_FLAGS, 32'hff);
    done("compare");
    // Shared channel switched to capture
    apb(1'b1, `TCP_OFF_ACC_CTRL, 32'h4);
    peek(2'h1, 33'h70, 33'hf0, "channel five released");
    pulse(4'hf);
    rd(`TCP_OFF_CC_FLAGS, 32'h0f, 32'hff, "capture flags");
    r = $random(seed) & 32'hff;
    apb(1'b1, `TCP_OFF_CC_MASK, r);
    peek(2'h2, {32'h0, |r[3:0]}, 33'h1, "masked irq");
    apb(1'b1, `TCP_OFF_CC_MASK, 32'h08);
    peek(2'h2, 33'h1, 33'h1, "shared enable irq");
    apb(1'b1, `TCP_OFF_CC_FLAGS, 32'h07);
    peek(2'h2, 33'h1, 33'h1, "irq kept");
    apb(1'b1, `TCP_OFF_CC_FLAGS, 32'h08);
    peek(2'h2, 33'h0, 33'h1, "irq cleared");
    apb(1'b1, `TCP_OFF_ACC_CTRL, 32'h0);
    pulse(4'h8);
    rd(`TCP_OFF_CC_FLAGS, 32'h0, 32'h08, "capture four ignored");
    apb(1'b1, `TCP_OFF_CC_MASK, 32'h0);
    apb(1'b1, `TCP_OFF_COUNT_HI, 32'hffff);
    rd(`TCP_OFF_COUNT_HI, 32'h0, 32'hff, "count high byte");
    note(2'h0, 33'h100000000, 33'h100000000, "unmapped error");
    apb(1'b0, 12'h040, 32'h0);
    done("capture");
    // Periodic timeout: 8192 cycles, whatever the prescaler
    wait_to(8100);
    rd(`TCP_OFF_MISC_FLAGS, 32'h0, 32'hff, "periodic early");
    wait_to(8300);
    rd(`TCP_OFF_MISC_FLAGS, 32'h40, 32'hff, "periodic flag");
    apb(1'b1, `TCP_OFF_MISC_MASK, 32'h40);
    peek(2'h2, 33'h1, 33'h1, "periodic irq");
    rd(`TCP_OFF_MISC_MASK, 32'h41, 32'hff, "prescale kept");
    apb(1'b1, `TCP_OFF_MISC_FLAGS, 32'h40);
    peek(2'h2, 33'h0, 33'h1, "periodic irq cleared");
    wait_to(16300);
    rd(`TCP_OFF_MISC_FLAGS, 32'h0, 32'hff, "second period early");
    wait_to(16480);
    rd(`TCP_OFF_MISC_FLAGS, 32'h40, 32'hff, "second period");
    done("periodic");
    // Mid-run reset reopens the prescale window; /16 checked by a match
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t0 = cyc;
    apb(1'b1, `TCP_OFF_MISC_MASK, 32'h3);
    apb(1'b1, `TCP_OFF_COMPARE_BASE, 32'h20);
    wait_to(t0 + 430);
    rd(`TCP_OFF_CC_FLAGS, 32'h0, 32'h80, "flag before div16 match");
    wait_to(t0 + 510);
    rd(`TCP_OFF_CC_FLAGS, 32'h80, 32'h80, "flag after div16 match");
    done("prescale sixteen");
    // Third reset: /1 so the count wraps; rate one for the periodic divider
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t0 = cyc;
    apb(1'b1, `TCP_OFF_MISC_MASK, 32'h80);
    apb(1'b1, `TCP_OFF_ACC_CTRL, 32'h1);
    wait_to(t0 + 16300);
    rd(`TCP_OFF_MISC_FLAGS, 32'h0, 32'h40, "rate one early");
    wait_to(t0 + 16480);
    rd(`TCP_OFF_MISC_FLAGS, 32'h40, 32'h40, "rate one period");
    wait_to(t0 + 65400);
    rd(`TCP_OFF_MISC_FLAGS, 32'h0, 32'h80, "no wrap yet");
    wait_to(t0 + 65600);
    rd(`TCP_OFF_MISC_FLAGS, 32'h80, 32'h80, "wrap flag");
    peek(2'h2, 33'h1, 33'h1, "wrap irq");
    peek(2'h1, 33'h0, 33'hff, "pins disconnected");
    apb(1'b1, `TCP_OFF_MISC_MASK, 32'h0);
    peek(2'h2, 33'h0, 33'h1, "wrap irq disabled");
    done("wrap");
    close_out();
  end
endmodule
`default_nettype wire
